// *** hdl/fpd_pkg.sv ***
// shared constants and types for the flash power-down, resume and id command block
package fpd_pkg;

  // ==========================================================================
  // opcodes
  localparam logic [7:0] OP_RESUME      = 8'h7A;
  localparam logic [7:0] OP_PWR_DOWN    = 8'hB9;
  localparam logic [7:0] OP_RELEASE     = 8'hAB;
  localparam logic [7:0] OP_MFR_ID      = 8'h90;
  localparam logic [7:0] OP_MFR_ID_DUAL = 8'h92;
  localparam logic [7:0] OP_MFR_ID_QUAD = 8'h94;
  localparam logic [7:0] OP_UNIQUE_ID   = 8'h4B;

  // ==========================================================================
  // link frame lengths, in serial clock rising edges
  localparam logic [7:0] OPC_CLK        = 8'h08;
  localparam logic [7:0] OPC_LAST       = 8'h07;
  localparam logic [7:0] REL_DUMMY_CLK  = 8'h18;
  localparam logic [7:0] MFR_ADDR_CLK   = 8'h18;
  localparam logic [7:0] DUAL_ADDR3_CLK = 8'h0C;
  localparam logic [7:0] DUAL_ADDR4_CLK = 8'h10;
  localparam logic [7:0] DUAL_MODE_CLK  = 8'h04;
  localparam logic [7:0] QUAD_DUMMY_CLK = 8'h04;
  localparam logic [7:0] QUAD_ADDR3_CLK = 8'h06;
  localparam logic [7:0] QUAD_ADDR4_CLK = 8'h08;
  localparam logic [7:0] QUAD_MODE_CLK  = 8'h02;
  localparam logic [7:0] UID_DUMMY_CLK  = 8'h20;
  localparam logic [7:0] CNT_RST        = 8'h00;
  localparam logic [5:0] OPOS_RST       = 6'h00;

  // ==========================================================================
  // system clock timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int RESUME_BUSY_NS = 200;
  localparam int PD_ENTRY_NS    = 3000;
  localparam int WAKE_NS        = 3000;
  localparam int WAKE_ID_NS     = 1800;
  localparam int TIMER_W        = 12;
  // longest time rounds down, least times round up
  localparam logic [TIMER_W-1:0] RESUME_BUSY_CYC = TIMER_W'(RESUME_BUSY_NS / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] PD_ENTRY_CYC    =
    TIMER_W'((PD_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] WAKE_CYC        =
    TIMER_W'((WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] WAKE_ID_CYC     =
    TIMER_W'((WAKE_ID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================================
  // types
  typedef struct packed {
    logic [7:0] opcode;
    logic       exact8;
  } fpd_cmd_t;

  typedef struct packed {
    logic asleep;
    logic busy;
    logic addr4;
  } fpd_lvl_t;

  localparam fpd_cmd_t CMD_RST = '{opcode: 8'h00, exact8: 1'b0};
  localparam fpd_lvl_t LVL_RST = '{asleep: 1'b0, busy: 1'b0, addr4: 1'b0};

  typedef enum logic [1:0] {
    PWR_NORMAL   = 2'b00,
    PWR_ENTERING = 2'b01,
    PWR_DOWN     = 2'b10,
    PWR_WAKING   = 2'b11
  } fpd_pwr_t;

  typedef enum logic [1:0] {
    LNK_OPCODE = 2'b00,
    LNK_HEADER = 2'b01,
    LNK_OUTPUT = 2'b10,
    LNK_IGNORE = 2'b11
  } fpd_lnk_t;

endpackage

// *** hdl/fpd_sync.sv ***
// two flip-flop level synchroniser
module fpd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // ==========================================================================
  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// *** hdl/fpd_timer.sv ***
// loadable down counter with a one-cycle done pulse
module fpd_timer #(
  parameter int W = 12
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         load,
  input  wire logic [W-1:0] cycles,
  output logic              running,
  output logic              done
);

  logic [W-1:0] cnt_reg;

  // ==========================================================================
  // counter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= '0;
      done    <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (load)
      begin
        cnt_reg <= cycles;
      end
      else if (cnt_reg != '0)
      begin
        cnt_reg <= cnt_reg - W'(1);
        done    <= (cnt_reg == W'(1));
      end
    end
  end

  assign running = (cnt_reg != '0);

endmodule

// *** hdl/fpd_cmd_core.sv ***
// resume, power-down and identification command handling of a serial flash
// ============================================================================
module fpd_cmd_core #(
  parameter logic [7:0]  MFR_ID    = 8'h5A,                  // arbitrary value
  parameter logic [7:0]  DEV_ID    = 8'h17,                  // arbitrary value
  parameter logic [63:0] UNIQUE_ID = 64'h0F1E_2D3C_4B5A_6978 // arbitrary value
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       spi_clk,
  input  wire logic       cs_n,
  input  wire logic [3:0] io_in,
  output logic      [3:0] io_out,
  output logic      [3:0] io_oe,
  input  wire logic       busy_in,
  input  wire logic       suspend_req,
  input  wire logic       power_loss,
  input  wire logic       addr4_mode,
  output logic            suspend_status_flag,
  output logic            busy_flag,
  output logic            resume_go,
  output logic            powered_down,
  output logic            ready
);

  // ==========================================================================
  // functions
  function automatic logic id_opcode(input logic [7:0] op);
    id_opcode = (op == fpd_pkg::OP_RELEASE) || (op == fpd_pkg::OP_MFR_ID) ||
                (op == fpd_pkg::OP_MFR_ID_DUAL) || (op == fpd_pkg::OP_MFR_ID_QUAD) ||
                (op == fpd_pkg::OP_UNIQUE_ID);
  endfunction

  // rising edges from frame start up to the last one before output
  function automatic logic [7:0] hdr_len(input logic [7:0] op, input logic a4);
    logic [7:0] len;
    len = fpd_pkg::OPC_CLK;
    case (op)
      fpd_pkg::OP_RELEASE:     len = fpd_pkg::OPC_CLK + fpd_pkg::REL_DUMMY_CLK;
      fpd_pkg::OP_MFR_ID:      len = fpd_pkg::OPC_CLK + fpd_pkg::MFR_ADDR_CLK;
      fpd_pkg::OP_MFR_ID_DUAL:
        len = fpd_pkg::OPC_CLK + fpd_pkg::DUAL_MODE_CLK +
              (a4 ? fpd_pkg::DUAL_ADDR4_CLK : fpd_pkg::DUAL_ADDR3_CLK);
      fpd_pkg::OP_MFR_ID_QUAD:
        len = fpd_pkg::OPC_CLK + fpd_pkg::QUAD_DUMMY_CLK + fpd_pkg::QUAD_MODE_CLK +
              (a4 ? fpd_pkg::QUAD_ADDR4_CLK : fpd_pkg::QUAD_ADDR3_CLK);
      fpd_pkg::OP_UNIQUE_ID:   len = fpd_pkg::OPC_CLK + fpd_pkg::UID_DUMMY_CLK;
      default:                 len = fpd_pkg::OPC_CLK;
    endcase
    return len;
  endfunction

  // ==========================================================================
  // declarations
  logic              frame_rst;
  fpd_pkg::fpd_lnk_t lnk_state_reg;
  logic [7:0]        cnt_reg;
  logic [7:0]        opc_reg;
  logic [7:0]        opc_next;
  logic [7:0]        op_reg;
  logic [7:0]        hdr_reg;
  logic [5:0]        opos_reg;
  fpd_pkg::fpd_cmd_t cmd_rec_reg;
  logic              cmd_tgl_reg;
  fpd_pkg::fpd_lvl_t lvl_sys_reg;
  fpd_pkg::fpd_lvl_t lvl_lnk;
  logic [63:0]       out_word;
  logic [5:0]        out_idx;
  logic [63:0]       out_rot;
  logic [3:0]        io_out_reg;
  logic [3:0]        io_oe_reg;

  logic [1:0]        frm_s;
  logic              cs_prev_reg;
  logic              tgl_seen_reg;
  logic              frame_end;
  fpd_pkg::fpd_pwr_t pwr_reg;
  logic              sus_reg;
  logic              resume_pend_reg;
  logic              resume_ok;
  logic              busy_flag_reg;
  logic              resume_go_reg;
  logic              powered_down_reg;
  logic              ready_reg;
  logic              pwr_load;
  logic [fpd_pkg::TIMER_W-1:0] pwr_cycles;
  logic              pwr_done;
  logic              rsm_done;

  // ==========================================================================
  // link domain: command shifter
  // chip select high ends the frame; the serial clock may stop outside it
  assign frame_rst = rst | cs_n;
  assign opc_next  = {opc_reg[6:0], io_in[0]};

  fpd_sync #(
    .W (3)
  ) u_lvl_sync (
    .clk (spi_clk),
    .rst (rst),
    .d   (lvl_sys_reg),
    .q   (lvl_lnk)
  );

  always_ff @(posedge spi_clk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      lnk_state_reg <= fpd_pkg::LNK_OPCODE;
      cnt_reg       <= fpd_pkg::CNT_RST;
      opc_reg       <= fpd_pkg::CNT_RST;
      op_reg        <= fpd_pkg::CNT_RST;
      hdr_reg       <= fpd_pkg::OPC_CLK;
      opos_reg      <= fpd_pkg::OPOS_RST;
    end
    else
    begin
      case (lnk_state_reg)
        fpd_pkg::LNK_OPCODE:
        begin
          opc_reg <= opc_next;
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == fpd_pkg::OPC_LAST)
          begin
            op_reg  <= opc_next;
            hdr_reg <= hdr_len(opc_next, lvl_lnk.addr4);
            // asleep: no id output; busy: no id output
            if (id_opcode(opc_next) && !lvl_lnk.asleep && !lvl_lnk.busy)
            begin
              lnk_state_reg <= fpd_pkg::LNK_HEADER;
            end
            else
            begin
              lnk_state_reg <= fpd_pkg::LNK_IGNORE;
            end
          end
        end
        fpd_pkg::LNK_HEADER:
        begin
          cnt_reg <= cnt_reg + 8'h01;
          if ((cnt_reg + 8'h01) == hdr_reg)
          begin
            lnk_state_reg <= fpd_pkg::LNK_OUTPUT;
          end
        end
        fpd_pkg::LNK_OUTPUT:
        begin
          opos_reg <= opos_reg + 6'h01;
        end
        default:
        begin
          lnk_state_reg <= fpd_pkg::LNK_IGNORE;
        end
      endcase
    end
  end

  // ==========================================================================
  // link domain: record of the last opcode for the system side
  // survives chip select; read by the system side only once cs is high again
  always_ff @(posedge spi_clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_rec_reg <= fpd_pkg::CMD_RST;
      cmd_tgl_reg <= 1'b0;
    end
    else if (!cs_n)
    begin
      if (lnk_state_reg == fpd_pkg::LNK_OPCODE && cnt_reg == fpd_pkg::OPC_LAST)
      begin
        cmd_rec_reg.opcode <= opc_next;
        cmd_rec_reg.exact8 <= 1'b1;
        cmd_tgl_reg        <= ~cmd_tgl_reg;
      end
      // any ninth edge spoils the exact frame
      else if (lnk_state_reg != fpd_pkg::LNK_OPCODE)
      begin
        cmd_rec_reg.exact8 <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // link domain: output serialiser
  // all streams fold into one 64-bit ring so every repeat length divides it
  always_comb
  begin
    case (op_reg)
      fpd_pkg::OP_RELEASE:   out_word = {8{DEV_ID}};
      fpd_pkg::OP_UNIQUE_ID: out_word = UNIQUE_ID;
      default:               out_word = {4{MFR_ID, DEV_ID}};
    endcase
    case (op_reg)
      fpd_pkg::OP_MFR_ID_DUAL: out_idx = {opos_reg[4:0], 1'b0};
      fpd_pkg::OP_MFR_ID_QUAD: out_idx = {opos_reg[3:0], 2'b00};
      default:                 out_idx = opos_reg;
    endcase
    out_rot = out_word << out_idx;
  end

  // falling edge launch, most significant first
  always_ff @(negedge spi_clk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      io_out_reg <= 4'h0;
      io_oe_reg  <= 4'h0;
    end
    else if (lnk_state_reg == fpd_pkg::LNK_OUTPUT)
    begin
      case (op_reg)
        fpd_pkg::OP_MFR_ID_DUAL:
        begin
          io_out_reg <= {2'b00, out_rot[63:62]};
          io_oe_reg  <= 4'h3;
        end
        fpd_pkg::OP_MFR_ID_QUAD:
        begin
          io_out_reg <= out_rot[63:60];
          io_oe_reg  <= 4'hF;
        end
        default:
        begin
          io_out_reg <= {2'b00, out_rot[63], 1'b0};
          io_oe_reg  <= 4'h2;
        end
      endcase
    end
    else
    begin
      io_out_reg <= 4'h0;
      io_oe_reg  <= 4'h0;
    end
  end

  assign io_out = io_out_reg;
  assign io_oe  = io_oe_reg;

  // ==========================================================================
  // system domain: frame end detection
  fpd_sync #(
    .W (2)
  // carried as select level so the synchroniser's reset value is the idle one
  ) u_frm_sync (
    .clk (clk_sys),
    .rst (rst),
    .d   ({~cs_n, cmd_tgl_reg}),
    .q   (frm_s)
  );

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cs_prev_reg  <= 1'b0;
      tgl_seen_reg <= 1'b0;
    end
    else if (ce)
    begin
      cs_prev_reg <= frm_s[1];
      if (!frm_s[1] && cs_prev_reg)
      begin
        tgl_seen_reg <= frm_s[0];
      end
    end
  end

  // record is stable here: no serial edge while chip select is high
  assign frame_end = !frm_s[1] && cs_prev_reg && (frm_s[0] != tgl_seen_reg);

  // ==========================================================================
  // system domain: suspend and resume
  // accept only when suspended and idle; not while asleep
  assign resume_ok = frame_end && (cmd_rec_reg.opcode == fpd_pkg::OP_RESUME) &&
                     sus_reg && !busy_in && (pwr_reg == fpd_pkg::PWR_NORMAL);

  // set wins over any clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sus_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (suspend_req && !sus_reg && busy_in)
      begin
        sus_reg <= 1'b1;
      end
      else if (power_loss)
      begin
        sus_reg <= 1'b0;
      end
      else if (resume_ok)
      begin
        sus_reg <= 1'b0;
      end
    end
  end

  fpd_timer #(
    .W (fpd_pkg::TIMER_W)
  ) u_rsm_timer (
    .clk     (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .load    (resume_ok),
    .cycles  (fpd_pkg::RESUME_BUSY_CYC),
    .running (),
    .done    (rsm_done)
  );

  // busy raised next cycle, held until engine takes over or the resume timer ends
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      resume_pend_reg <= 1'b0;
      busy_flag_reg   <= 1'b0;
      resume_go_reg   <= 1'b0;
    end
    else if (ce)
    begin
      resume_go_reg <= resume_ok;
      busy_flag_reg <= busy_in || resume_ok || (resume_pend_reg && !rsm_done);
      if (resume_ok)
      begin
        resume_pend_reg <= 1'b1;
      end
      else if (busy_in || rsm_done)
      begin
        resume_pend_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // system domain: power state
  always_comb
  begin
    pwr_load   = 1'b0;
    pwr_cycles = fpd_pkg::PD_ENTRY_CYC;
    if (frame_end)
    begin
      case (pwr_reg)
        fpd_pkg::PWR_NORMAL:
        begin
          // only a bare opcode frame counts
          pwr_load = (cmd_rec_reg.opcode == fpd_pkg::OP_PWR_DOWN) &&
                     cmd_rec_reg.exact8 && !busy_in;
        end
        fpd_pkg::PWR_DOWN:
        begin
          pwr_load   = (cmd_rec_reg.opcode == fpd_pkg::OP_RELEASE);
          pwr_cycles = cmd_rec_reg.exact8 ? fpd_pkg::WAKE_CYC : fpd_pkg::WAKE_ID_CYC;
        end
        default:
        begin
          pwr_load = 1'b0;
        end
      endcase
    end
  end

  fpd_timer #(
    .W (fpd_pkg::TIMER_W)
  ) u_pwr_timer (
    .clk     (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .load    (pwr_load),
    .cycles  (pwr_cycles),
    .running (),
    .done    (pwr_done)
  );

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pwr_reg <= fpd_pkg::PWR_NORMAL;
    end
    else if (ce)
    begin
      case (pwr_reg)
        fpd_pkg::PWR_NORMAL:
        begin
          if (pwr_load)
          begin
            pwr_reg <= fpd_pkg::PWR_ENTERING;
          end
        end
        fpd_pkg::PWR_ENTERING:
        begin
          if (pwr_done)
          begin
            pwr_reg <= fpd_pkg::PWR_DOWN;
          end
        end
        fpd_pkg::PWR_DOWN:
        begin
          if (pwr_load)
          begin
            pwr_reg <= fpd_pkg::PWR_WAKING;
          end
        end
        fpd_pkg::PWR_WAKING:
        begin
          // accept again only after wake time
          if (pwr_done)
          begin
            pwr_reg <= fpd_pkg::PWR_NORMAL;
          end
        end
        default:
        begin
          pwr_reg <= fpd_pkg::PWR_NORMAL;
        end
      endcase
    end
  end

  // ==========================================================================
  // system domain: status outputs and levels toward the link
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      powered_down_reg <= 1'b0;
      ready_reg        <= 1'b0;
      lvl_sys_reg      <= fpd_pkg::LVL_RST;
    end
    else if (ce)
    begin
      powered_down_reg   <= (pwr_reg == fpd_pkg::PWR_DOWN);
      ready_reg          <= (pwr_reg == fpd_pkg::PWR_NORMAL);
      lvl_sys_reg.asleep <= (pwr_reg != fpd_pkg::PWR_NORMAL);
      lvl_sys_reg.busy   <= busy_in || resume_pend_reg;
      lvl_sys_reg.addr4  <= addr4_mode;
    end
  end

  assign suspend_status_flag = sus_reg;
  assign busy_flag           = busy_flag_reg;
  assign resume_go           = resume_go_reg;
  assign powered_down        = powered_down_reg;
  assign ready               = ready_reg;

endmodule

// *** test/fpd_host_model.sv ***
// host side serial flash controller model
module fpd_host_model (
  output logic            spi_clk,
  output logic            cs_n,
  output logic      [3:0] io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] rd;
  logic        oe_any;

  // ==========================================================================
  // idle: clock stands low, chip select high
  initial
  begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h0;
    rd = 64'h0;
    oe_any = 1'b0;
  end

  // ==========================================================================
  // one frame, 80 ns serial clock; released lanes toggle every cycle
  task automatic frame(input logic [7:0] op, input int hdr, input int m, input int nrd,
                       input int w);
    int i;
    #13;
    rd = 64'h0;
    oe_any = 1'b0;
    cs_n = 1'b0;
    for (i = 0; i < 8 + hdr + nrd; i++)
    begin
      // opcode msb first on lane 0
      if (i < 8)
        io_in = {3'h0, op[7-i]};
      else if (i < 8 + hdr)
        io_in = (i >= 8 + hdr - m) ? 4'hF : 4'h0;
      else
        io_in = ~io_in;
      #40 spi_clk = 1'b1;
      if (i >= 8 + hdr)
      begin
        oe_any = oe_any | (io_oe != 4'h0);
        rd = (w == 4) ? {rd[59:0], io_out} :
             (w == 2) ? {rd[61:0], io_out[1:0]} : {rd[62:0], io_out[1]};
      end
      #40 spi_clk = 1'b0;
    end
    // deselect right after the last latched bit
    #40 cs_n = 1'b1;
  endtask
endmodule

// *** test/fpd_cmd_monitor.sv ***
// port level checks for the command block
module fpd_cmd_monitor (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       spi_clk,
  input wire logic       cs_n,
  input wire logic [3:0] io_oe,
  input wire logic       busy_in,
  input wire logic       suspend_req,
  input wire logic       power_loss,
  input wire logic       suspend_status_flag,
  input wire logic       busy_flag,
  input wire logic       resume_go,
  input wire logic       powered_down,
  input wire logic       ready
);
  logic [9:0] asleep_cnt;

  // ==========================================================================
  // cycles spent entering or waking
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      asleep_cnt <= 10'h000;
    else
      asleep_cnt <= (ready || powered_down) ? 10'h000 : asleep_cnt + 10'h001;
  end

  sequence s_accept;
    $past(suspend_status_flag) && !$past(busy_in) && $past(ready);
  endsequence
  sequence s_started;
    (!suspend_status_flag && busy_flag) ##1 (!resume_go && busy_flag);
  endsequence

  // ==========================================================================
  // assertions
  property p_go_cause;
    @(posedge clk_sys) disable iff (rst) resume_go |-> s_accept;
  endproperty
  a_go_cause: assert property (p_go_cause) else $error("resume without suspend");
  property p_go_effect;
    @(posedge clk_sys) disable iff (rst) resume_go |-> s_started;
  endproperty
  a_go_effect: assert property (p_go_effect) else $error("resume effects wrong");
  property p_sus_set;
    @(posedge clk_sys) disable iff (rst)
      ce && suspend_req && busy_in && !suspend_status_flag |=> suspend_status_flag;
  endproperty
  a_sus_set: assert property (p_sus_set) else $error("suspend flag not set");
  property p_loss;
    @(posedge clk_sys) disable iff (rst)
      ce && power_loss && !suspend_req |=> !suspend_status_flag;
  endproperty
  a_loss: assert property (p_loss) else $error("power loss kept suspend");
  property p_pd_entry;
    @(posedge clk_sys) disable iff (rst) $rose(powered_down) |-> !$past(ready, 250);
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down too early");
  property p_sleep_bound;
    @(posedge clk_sys) disable iff (rst) asleep_cnt < 10'h140;
  endproperty
  a_sleep_bound: assert property (p_sleep_bound) else $error("transition too long");
  property p_pd_ready;
    @(posedge clk_sys) disable iff (rst) powered_down |-> !ready;
  endproperty
  a_pd_ready: assert property (p_pd_ready) else $error("ready while down");
  property p_pd_quiet;
    @(posedge spi_clk) disable iff (rst) powered_down |-> io_oe == 4'h0;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("output while down");
  property p_deselect;
    @(posedge clk_sys) disable iff (rst) cs_n |-> io_oe == 4'h0;
  endproperty
  a_deselect: assert property (p_deselect) else $error("driving while deselected");
endmodule

bind fpd_cmd_core fpd_cmd_monitor mon (.clk_sys(clk_sys), .rst(rst), .ce(ce),
  .spi_clk(spi_clk), .cs_n(cs_n), .io_oe(io_oe), .busy_in(busy_in),
  .suspend_req(suspend_req), .power_loss(power_loss),
  .suspend_status_flag(suspend_status_flag), .busy_flag(busy_flag),
  .resume_go(resume_go), .powered_down(powered_down), .ready(ready));

// *** test/fpd_cmd_core_tb_top.sv ***
// self-checking bench for the command block
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_count++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module fpd_cmd_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0]  MF = 8'h5A;                  // arbitrary value
  localparam logic [7:0]  DV = 8'h17;                  // arbitrary value
  localparam logic [63:0] UID = 64'h0F1E_2D3C_4B5A_6978; // arbitrary value
  localparam logic [63:0] MD = {32'h0, MF, DV, MF, DV};
  logic clk_sys, rst, ce, busy_in, suspend_req, power_loss, addr4_mode;
  logic spi_clk, cs_n, suspend_status_flag, busy_flag, resume_go, powered_down, ready;
  logic [3:0] io_in, io_out, io_oe;
  int err_count, checked, go_cnt;

  fpd_cmd_core #(.MFR_ID(MF), .DEV_ID(DV), .UNIQUE_ID(UID)) dut (.clk_sys(clk_sys),
    .rst(rst), .ce(ce), .spi_clk(spi_clk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .busy_in(busy_in), .suspend_req(suspend_req), .power_loss(power_loss),
    .addr4_mode(addr4_mode), .suspend_status_flag(suspend_status_flag),
    .busy_flag(busy_flag), .resume_go(resume_go), .powered_down(powered_down),
    .ready(ready));
  fpd_host_model host (.spi_clk(spi_clk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (resume_go === 1'b1)
      go_cnt++;
  initial
  begin
    #900000;
    err_count++;
    conclude();
  end

  task automatic conclude();
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op, input int hdr, input int m, input int nrd,
                     input int w);
    host.frame(op, hdr, m, nrd, w);
    repeat (10) @(posedge clk_sys);
    #1;
  endtask
  task automatic id_read(input logic [7:0] op, input int hdr, input int m, input int nrd,
                         input int w, input logic [63:0] exp);
    cmd(op, hdr, m, nrd, w);
    `CHK("id_data", exp, host.rd)
  endtask
  // bounded wait on ready, resume_go or powered_down
  task automatic wait_on(input int sel, input logic v, input int lim);
    int n;
    for (n = 0; n < lim && ((sel == 0 ? ready : sel == 1 ? resume_go : powered_down) !== v);
         n++)
    begin
      @(posedge clk_sys);
      #1;
    end
    if (n == lim)
    begin
      err_count++;
      conclude();
    end
  endtask

  // ==========================================================================
  // main sequence
  initial
  begin
    {rst, ce, busy_in, suspend_req, power_loss, addr4_mode} = 6'h30;
    {err_count, checked, go_cnt} = '0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK("ready", 1'b1, ready)
    `CHK("powered_down", 1'b0, powered_down)
    id_read(8'h90, 24, 0, 32, 1, MD);
    id_read(8'hAB, 24, 0, 32, 1, {32'h0, {4{DV}}});
    id_read(8'h92, 16, 4, 16, 2, MD);
    id_read(8'h94, 12, 2, 8, 4, MD);
    id_read(8'h4B, 32, 0, 64, 1, UID);
    @(posedge clk_sys) addr4_mode <= 1'b1;
    id_read(8'h92, 20, 4, 16, 2, MD);
    id_read(8'h94, 14, 2, 8, 4, MD);
    @(posedge clk_sys) {addr4_mode, busy_in} <= 2'b01;
    cmd(8'h90, 24, 0, 32, 1);
    `CHK("oe_busy", 1'b0, host.oe_any)
    cmd(8'hAB, 24, 0, 16, 1);
    `CHK("oe_busy", 1'b0, host.oe_any)
    cmd(8'h7A, 0, 0, 0, 1);
    `CHK("go_cnt", 0, go_cnt)
    @(posedge clk_sys) suspend_req <= 1'b1;
    @(posedge clk_sys) suspend_req <= 1'b0;
    @(posedge clk_sys) #1;
    `CHK("suspend_status_flag", 1'b1, suspend_status_flag)
    cmd(8'h7A, 0, 0, 0, 1);
    `CHK("go_cnt", 0, go_cnt)
    @(posedge clk_sys) busy_in <= 1'b0;
    host.frame(8'h7A, 0, 0, 0, 1);
    wait_on(1, 1'b1, 20);
    `CHK("busy_flag", 1'b1, busy_flag)
    `CHK("suspend_status_flag", 1'b0, suspend_status_flag)
    // engine resumes; wait before the next suspend
    @(posedge clk_sys) busy_in <= 1'b1;
    repeat (40) @(posedge clk_sys);
    suspend_req <= 1'b1;
    @(posedge clk_sys) {suspend_req, power_loss} <= 2'b01;
    @(posedge clk_sys) {power_loss, busy_in} <= 2'b00;
    cmd(8'h7A, 0, 0, 0, 1);
    `CHK("go_cnt", 1, go_cnt)
    cmd(8'hB9, 1, 0, 0, 1);
    `CHK("ready", 1'b1, ready)
    cmd(8'hB9, 0, 0, 0, 1);
    `CHK("ready", 1'b0, ready)
    wait_on(2, 1'b1, 320);
    cmd(8'h90, 24, 0, 16, 1);
    `CHK("oe_down", 1'b0, host.oe_any)
    `CHK("powered_down", 1'b1, powered_down)
    // chip select stays high while waking
    cmd(8'hAB, 0, 0, 0, 1);
    wait_on(0, 1'b1, 320);
    `CHK("powered_down", 1'b0, powered_down)
    cmd(8'hB9, 0, 0, 0, 1);
    wait_on(2, 1'b1, 320);
    cmd(8'hAB, 24, 0, 8, 1);
    `CHK("oe_wake_id", 1'b0, host.oe_any)
    // chip select stays high through the shorter id wake
    wait_on(0, 1'b1, 200);
    conclude();
  end
endmodule
